// file: byte_shift.v
// one data byte: loadable from software, shifts toward the lsb with a new msb
`timescale 1ns/1ps
module byte_shift #(
  parameter W = 8
) (
  input wire pclk,
  input wire presetn,
  input wire clear,
  input wire load,
  input wire [W-1:0] load_data,
  input wire shift,
  input wire shift_in,
  output reg [W-1:0] q
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= {W{1'b0}};
    end else if (clear) begin
      q <= {W{1'b0}};
    end else if (load) begin
      q <= load_data;
    end else if (shift) begin
      q <= {shift_in, q[W-1:1]};
    end
  end
endmodule

// file: clock_prescaler.v
// free-running prescaler that gives the selected serial clock level and its edges
`timescale 1ns/1ps
module clock_prescaler #(
  parameter [3:0] SUB_TAP = 4'ha
) (
  input wire pclk,
  input wire presetn,
  input wire [2:0] div_sel,
  output wire level,
  output wire rise_tick,
  output wire fall_tick
);
`include "sync_serial_map.vh"
  reg [`PRE_WIDTH-1:0] count;
  reg level_prev;
  reg [3:0] tap;

  always @* begin
    case (div_sel)
      3'h0: tap = `TAP_DIV1024;
      3'h1: tap = `TAP_DIV256;
      3'h2: tap = `TAP_DIV64;
      3'h3: tap = `TAP_DIV32;
      3'h4: tap = `TAP_DIV16;
      3'h5: tap = `TAP_DIV8;
      3'h6: tap = `TAP_DIV4;
      default: tap = SUB_TAP;
    endcase
  end

  // a tap bit toggles every half period, so the clock is high then low for equal time
  assign level = ~count[tap];
  assign rise_tick = level & ~level_prev;
  assign fall_tick = ~level & level_prev;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= {`PRE_WIDTH{1'b0}};
      level_prev <= 1'b1;
    end else begin
      count <= count + {{(`PRE_WIDTH-1){1'b0}}, 1'b1};
      level_prev <= level;
    end
  end
endmodule

// file: sync_peer_model.sv
// behavioural far-side serial peripheral on the shared clock and data lines
`timescale 1ns/1ps
module sync_peer_model (
  input wire pclk,
  input wire sck,
  input wire so,
  output reg si,
  output reg peer_sck
);
  reg [15:0] tx = 16'h0000;
  reg [15:0] rx = 16'h0000;
  reg [4:0] left = 5'h00;
  reg sampled = 1'b0;
  initial begin
    si = 1'b0;
    peer_sck = 1'b1;
  end
  task load(input [15:0] d, input [4:0] n);
    begin
      tx = d;
      rx = 16'h0000;
      left = n;
      si = d[0];
      sampled = 1'b0;
    end
  endtask
  always @(posedge sck) begin
    if (left != 5'h00) begin
      rx = {so, rx[15:1]};
      left = left - 5'h01;
      sampled = 1'b1;
    end
  end
  // after the last bit the line is inverted so a stale level never looks valid
  always @(negedge sck) begin
    if (sampled) begin
      tx = tx >> 1;
      si = (left == 5'h00) ? ~si : tx[0];
      sampled = (left != 5'h00);
    end
  end
  // clock stands high between bursts: no free-running source here
  task clock_out(input integer n, input integer half);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        repeat (half) @(posedge pclk);
        peer_sck <= 1'b0;
        repeat (half) @(posedge pclk);
        peer_sck <= 1'b1;
      end
    end
  endtask
endmodule

// file: sync_serial_map.vh
// register map, field positions and reset values of the synchronous serial port
`ifndef SYNC_SERIAL_MAP_VH
`define SYNC_SERIAL_MAP_VH
// ------------------------------------------------------------
// byte addresses on the register bus
// ------------------------------------------------------------
`define ADDR_CONTROL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_HIGH_BYTE 12'h008
`define ADDR_LOW_BYTE 12'h00c
`define ADDR_PORT_MODE 12'h010
`define ADDR_CLOCK_STOP 12'h014
`define ADDR_IRQ 12'h018
// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define CTL_FMT_HI 7
`define CTL_FMT_LO 6
`define CTL_TAIL_EN 5
`define CTL_TAIL_TYPE 4
`define CTL_CLK_EXT 3
`define CTL_DIV_HI 2
`define CTL_DIV_LO 0
`define CTL_RESET 8'h00
`define FMT_CONTINUOUS 2'b10
// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define STS_FIXED_ONE 7
`define STS_OUT_LEVEL 6
`define STS_OVERRUN 5
`define STS_TAIL_BUSY 1
`define STS_START 0
// ------------------------------------------------------------
// port mode, clock stop and request register fields
// ------------------------------------------------------------
`define PMR_SO_EN 0
`define PMR_SI_EN 1
`define PMR_SCK_EN 2
`define PMR_OPEN_DRAIN 3
`define PMR_RESET 4'h0
`define STOP_PORT_BIT 7
`define STOP_RESET 8'hff
`define IRQ_DONE_BIT 0
// ------------------------------------------------------------
// transfer lengths, tail lengths and prescaler tap positions
// ------------------------------------------------------------
`define LEN_BYTE 5'h08
`define LEN_WORD 5'h10
`define HOLD_STEPS 3'h3
`define LATCH_STEPS 3'h4
`define PRE_WIDTH 11
`define TAP_DIV1024 4'h9
`define TAP_DIV256 4'h7
`define TAP_DIV64 4'h5
`define TAP_DIV32 4'h4
`define TAP_DIV16 4'h3
`define TAP_DIV8 4'h2
`define TAP_DIV4 4'h1
`endif

// file: sync_serial_tail_mark_port.v
// synchronous serial port with two-wire tail marks, reached over apb
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module sync_serial_tail_mark_port #(
  parameter [3:0] SUB_TAP = 4'ha
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire serial_in_pin,
  input wire serial_clock_pin_i,
  output reg serial_clock_pin_o,
  output reg serial_clock_pin_oe,
  output reg serial_out_pin_o,
  output reg serial_out_pin_oe,
  output reg transfer_done_request
);
`include "sync_serial_map.vh"
  // ------------------------------------------------------------
  // registers and state
  // ------------------------------------------------------------
  reg [7:0] serial_control_reg;
  reg [3:0] port_mode_reg;
  reg [7:0] module_clock_stop;
  reg out_level;
  reg overrun_flag;
  reg start_busy_flag;
  reg started;
  reg done_seen;
  reg tail_on;
  reg [2:0] tail_step;
  reg [4:0] bit_cnt;
  reg ext_prev;
  reg [7:0] read_mux;
  wire [7:0] serial_low_byte;
  wire [7:0] serial_high_byte;
  wire p_level;
  wire p_rise;
  wire p_fall;

  wire standby = ~module_clock_stop[`STOP_PORT_BIT];
  wire ext_clk = serial_control_reg[`CTL_CLK_EXT];
  wire tail_en = serial_control_reg[`CTL_TAIL_EN];
  wire tail_latch = serial_control_reg[`CTL_TAIL_TYPE];
  wire word_mode = serial_control_reg[`CTL_FMT_LO];
  wire [1:0] fmt = {serial_control_reg[`CTL_FMT_HI], serial_control_reg[`CTL_FMT_LO]};
  wire continuous = (fmt == `FMT_CONTINUOUS);
  wire open_drain = port_mode_reg[`PMR_OPEN_DRAIN];
  wire si_level = serial_in_pin & port_mode_reg[`PMR_SI_EN];

  // ------------------------------------------------------------
  // apb decode: one wait state so read data comes from a flop
  // ------------------------------------------------------------
  wire access = psel & penable;
  wire commit = access & pready;
  wire wr = commit & pwrite & ~pslverr;
  wire mapped = (paddr == `ADDR_CONTROL) | (paddr == `ADDR_STATUS) |
                (paddr == `ADDR_HIGH_BYTE) | (paddr == `ADDR_LOW_BYTE) |
                (paddr == `ADDR_PORT_MODE) | (paddr == `ADDR_CLOCK_STOP) |
                (paddr == `ADDR_IRQ);
  wire wr_ctl = wr & (paddr == `ADDR_CONTROL) & ~standby;
  wire wr_sts = wr & (paddr == `ADDR_STATUS) & ~standby;
  wire wr_high = wr & (paddr == `ADDR_HIGH_BYTE) & ~standby;
  wire wr_low = wr & (paddr == `ADDR_LOW_BYTE) & ~standby;
  wire reinit = wr_ctl & ~pwdata[`CTL_TAIL_EN];
  wire idle = ~start_busy_flag & ~tail_on;
  wire start_req = wr_sts & pwdata[`STS_START] & idle & ~continuous;

  always @* begin
    read_mux = 8'h00;
    if (paddr == `ADDR_CONTROL) begin
      read_mux = serial_control_reg;
    end else if (paddr == `ADDR_STATUS) begin
      read_mux[`STS_FIXED_ONE] = 1'b1;
      read_mux[`STS_OUT_LEVEL] = out_level;
      read_mux[`STS_OVERRUN] = overrun_flag;
      read_mux[`STS_TAIL_BUSY] = tail_on;
      read_mux[`STS_START] = start_busy_flag;
    end else if (paddr == `ADDR_HIGH_BYTE) begin
      read_mux = serial_high_byte;
    end else if (paddr == `ADDR_LOW_BYTE) begin
      read_mux = serial_low_byte;
    end else if (paddr == `ADDR_PORT_MODE) begin
      read_mux = {4'h0, port_mode_reg};
    end else if (paddr == `ADDR_CLOCK_STOP) begin
      read_mux = module_clock_stop;
    end else if (paddr == `ADDR_IRQ) begin
      read_mux[`IRQ_DONE_BIT] = transfer_done_request;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      if (access & ~pready) begin
        prdata <= {24'h000000, read_mux};
      end
    end
  end

  // ------------------------------------------------------------
  // clock source and edge selection
  // ------------------------------------------------------------
  clock_prescaler #(
    .SUB_TAP(SUB_TAP)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .div_sel(serial_control_reg[`CTL_DIV_HI:`CTL_DIV_LO]),
    .level(p_level),
    .rise_tick(p_rise),
    .fall_tick(p_fall)
  );

  wire ext_rise = serial_clock_pin_i & ~ext_prev;
  wire ext_fall = ~serial_clock_pin_i & ext_prev;
  // internal transfers wait for a prescaler fall so the first bit gets a full period
  wire shifting = start_busy_flag & (ext_clk | started | p_fall);
  wire edge_rise = shifting & (ext_clk ? ext_rise : p_rise);
  wire edge_fall = shifting & (ext_clk ? ext_fall : p_fall);
  wire [4:0] len = word_mode ? `LEN_WORD : `LEN_BYTE;
  wire last_bit = edge_rise & (bit_cnt == len - 5'h01);
  wire late_edge = ext_clk & ~start_busy_flag & done_seen & (ext_rise | ext_fall);

  // ------------------------------------------------------------
  // data bytes
  // ------------------------------------------------------------
  byte_shift #(
    .W(8)
  ) u_high (
    .pclk(pclk),
    .presetn(presetn),
    .clear(standby),
    .load(wr_high),
    .load_data(pwdata[7:0]),
    .shift(edge_rise & word_mode),
    .shift_in(si_level),
    .q(serial_high_byte)
  );

  byte_shift #(
    .W(8)
  ) u_low (
    .pclk(pclk),
    .presetn(presetn),
    .clear(standby),
    .load(wr_low),
    .load_data(pwdata[7:0]),
    .shift(edge_rise),
    .shift_in(word_mode ? serial_high_byte[0] : si_level),
    .q(serial_low_byte)
  );

  // ------------------------------------------------------------
  // tail mark waveform, one step per serial clock cycle
  // ------------------------------------------------------------
  reg tail_sck;
  reg tail_so;
  always @* begin
    tail_sck = 1'b1;
    tail_so = 1'b1;
    case ({tail_latch, tail_step})
      4'h0: begin
        tail_sck = 1'b0;
        tail_so = 1'b0;
      end
      4'h1: tail_so = 1'b0;
      4'h8: begin
        tail_sck = 1'b0;
        tail_so = 1'b1;
      end
      4'ha: tail_so = 1'b0;
      default: tail_so = 1'b1;
    endcase
  end
  wire [2:0] tail_len = tail_latch ? `LATCH_STEPS : `HOLD_STEPS;

  // ------------------------------------------------------------
  // transfer control
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_control_reg <= `CTL_RESET;
      port_mode_reg <= `PMR_RESET;
      module_clock_stop <= `STOP_RESET;
      out_level <= 1'b0;
      overrun_flag <= 1'b0;
      start_busy_flag <= 1'b0;
      started <= 1'b0;
      done_seen <= 1'b0;
      tail_on <= 1'b0;
      tail_step <= 3'h0;
      bit_cnt <= 5'h00;
      ext_prev <= 1'b1;
      transfer_done_request <= 1'b0;
    end else begin
      ext_prev <= serial_clock_pin_i;
      if (wr & (paddr == `ADDR_CLOCK_STOP)) begin
        module_clock_stop <= pwdata[7:0];
      end
      if (wr & (paddr == `ADDR_PORT_MODE)) begin
        port_mode_reg <= pwdata[3:0];
      end
      if (last_bit) begin
        transfer_done_request <= 1'b1;
      end else if (wr & (paddr == `ADDR_IRQ) & ~pwdata[`IRQ_DONE_BIT]) begin
        transfer_done_request <= 1'b0;
      end
      if (standby) begin
        serial_control_reg <= `CTL_RESET;
        out_level <= 1'b0;
        overrun_flag <= 1'b0;
        start_busy_flag <= 1'b0;
        started <= 1'b0;
        done_seen <= 1'b0;
        tail_on <= 1'b0;
        tail_step <= 3'h0;
        bit_cnt <= 5'h00;
      end else if (reinit) begin
        serial_control_reg <= pwdata[7:0];
        start_busy_flag <= 1'b0;
        started <= 1'b0;
        done_seen <= 1'b0;
        tail_on <= 1'b0;
        tail_step <= 3'h0;
        bit_cnt <= 5'h00;
      end else begin
        if (wr_ctl) begin
          serial_control_reg <= pwdata[7:0];
        end
        if (late_edge) begin
          overrun_flag <= 1'b1;
        end else if (wr_sts & ~pwdata[`STS_OVERRUN]) begin
          overrun_flag <= 1'b0;
        end
        if (wr_sts & idle & ~tail_en) begin
          out_level <= pwdata[`STS_OUT_LEVEL];
        end else if (edge_fall) begin
          out_level <= serial_low_byte[0];
        end
        if (start_req) begin
          start_busy_flag <= 1'b1;
          started <= 1'b0;
          done_seen <= 1'b0;
          bit_cnt <= 5'h00;
        end else if (last_bit) begin
          start_busy_flag <= 1'b0;
          started <= 1'b0;
          done_seen <= 1'b1;
          tail_on <= tail_en;
          tail_step <= 3'h0;
        end else begin
          if (shifting & ~ext_clk) begin
            started <= 1'b1;
          end
          if (edge_rise) begin
            bit_cnt <= bit_cnt + 5'h01;
          end
        end
        // the tail advances on whole serial clock cycles of the divider
        if (tail_on & p_fall) begin
          if (tail_step == tail_len - 3'h1) begin
            tail_on <= 1'b0;
            tail_step <= 3'h0;
            // the line rests at the mark's closing level, not the stale data bit
            out_level <= tail_so;
          end else begin
            tail_step <= tail_step + 3'h1;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // pin drivers, registered
  // ------------------------------------------------------------
  // the outgoing bit goes straight to the pin so data and clock fall together
  wire so_level = tail_on ? tail_so : (edge_fall ? serial_low_byte[0] : out_level);
  reg next_sck_o;
  always @* begin
    next_sck_o = 1'b1;
    if (continuous) begin
      next_sck_o = p_level;
    end else if (tail_on) begin
      next_sck_o = tail_sck;
    end else if (shifting) begin
      next_sck_o = p_level;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_clock_pin_o <= 1'b1;
      serial_clock_pin_oe <= 1'b0;
      serial_out_pin_o <= 1'b0;
      serial_out_pin_oe <= 1'b0;
    end else begin
      serial_clock_pin_o <= next_sck_o;
      serial_clock_pin_oe <= port_mode_reg[`PMR_SCK_EN] & ~ext_clk;
      // open drain only pulls low; a high level is left to the pull-up
      serial_out_pin_o <= open_drain ? 1'b0 : so_level;
      serial_out_pin_oe <= port_mode_reg[`PMR_SO_EN] & (~open_drain | ~so_level);
    end
  end
endmodule

// file: sync_serial_tail_mark_port_props.sv
// concurrent checks on the ports of the synchronous serial port
`timescale 1ns/1ps
`include "sync_serial_map.vh"
module serial_port_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire serial_in_pin,
  input wire serial_clock_pin_i,
  input wire serial_clock_pin_o,
  input wire serial_clock_pin_oe,
  input wire serial_out_pin_o,
  input wire serial_out_pin_oe,
  input wire transfer_done_request
);
  // ------------------------------------------------------------
  // shadow of control, cleared pessimistically while in standby
  // ------------------------------------------------------------
  wire wr = psel && penable && pready && pwrite;
  reg [7:0] ctl_seen;
  reg stop_seen;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_seen <= 8'h00;
      stop_seen <= 1'b1;
    end else begin
      if (wr && paddr == `ADDR_CLOCK_STOP)
        stop_seen <= pwdata[`STOP_PORT_BIT];
      if (!stop_seen)
        ctl_seen <= 8'h00;
      else if (wr && paddr == `ADDR_CONTROL)
        ctl_seen <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY_AFTER_ACCESS: assert property (psel && penable && !pready |=> pready)
    else $error("no ready after access cycle");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_READY_CAUSE: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  AST_SLVERR_MAP: assert property (pready |-> pslverr == (paddr > `ADDR_IRQ || paddr[1:0] != 2'b00))
    else $error("slave error against address map");
  AST_READ_UPPER: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  AST_STATUS_FIXED: assert property (pready && !pwrite && paddr == `ADDR_STATUS
    |-> prdata[7] && prdata[4:2] == 3'b000)
    else $error("fixed status bits wrong");
  AST_SO_STEADY_LOW: assert property (
    serial_clock_pin_oe && !serial_clock_pin_o && $past(!serial_clock_pin_o)
    |-> $stable(serial_out_pin_o))
    else $error("data moved while clock low");
  AST_DONE_HOLD: assert property (
    transfer_done_request && !(wr && paddr == `ADDR_IRQ) |=> transfer_done_request)
    else $error("done request dropped");
  AST_CLK_QUIET: assert property (
    $rose(transfer_done_request) && serial_clock_pin_oe && !ctl_seen[`CTL_TAIL_EN]
    |-> ##[0:1] serial_clock_pin_o ##1 serial_clock_pin_o[*4])
    else $error("clock ran after transfer");
  AST_EXT_NO_DRIVE: assert property (
    ctl_seen[`CTL_CLK_EXT] && $past(ctl_seen[`CTL_CLK_EXT]) |-> !serial_clock_pin_oe)
    else $error("clock driven with external source");
endmodule
bind sync_serial_tail_mark_port serial_port_props i_serial_port_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_in_pin(serial_in_pin), .serial_clock_pin_i(serial_clock_pin_i),
  .serial_clock_pin_o(serial_clock_pin_o), .serial_clock_pin_oe(serial_clock_pin_oe),
  .serial_out_pin_o(serial_out_pin_o), .serial_out_pin_oe(serial_out_pin_oe),
  .transfer_done_request(transfer_done_request));

// file: test_sync_serial_tail_mark_port.sv
// self-checking bench for the synchronous serial port
`timescale 1ns/1ps
`include "sync_serial_map.vh"
module test_sync_serial_tail_mark_port;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, sck_o, sck_oe, so_o, so_oe, done, si, peer_sck;
  wire sck_w = sck_oe ? sck_o : peer_sck;
  // output line has a pull-up when released
  wire so_w = so_oe ? so_o : 1'b1;
  integer err_count = 0;
  integer samples_checked = 0;
  integer cycles = 0;
  integer i;
  integer edges;
  reg [31:0] rd;
  reg bad;
  reg tail_seen;
  reg last;
  always #25 pclk = ~pclk;
  sync_serial_tail_mark_port i_sync_serial_tail_mark_port (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in_pin(si),
    .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o), .serial_clock_pin_oe(sck_oe),
    .serial_out_pin_o(so_o), .serial_out_pin_oe(so_oe), .transfer_done_request(done));
  sync_peer_model i_sync_peer_model (.pclk(pclk), .sck(sck_w), .so(so_w), .si(si),
    .peer_sck(peer_sck));
  // ------------------------------------------------------------
  // bus and comparison helpers
  // ------------------------------------------------------------
  task check(input string name, input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("ERROR %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge pclk);
        n = n + 1;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      bad = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) check("pready", 0, 1);
    end
  endtask
  task rdc(input [11:0] a, input [31:0] exp, input string name);
    begin
      apb(1'b0, a, 32'h0);
      check(name, rd, exp);
    end
  endtask
  // two idle reads in a row, so a gap between data and tail is not taken for the end
  task wait_idle;
    integer n;
    integer ok;
    begin
      n = 0;
      ok = 0;
      do begin
        apb(1'b0, `ADDR_STATUS, 32'h0);
        if (rd[1] === 1'b1) tail_seen = 1'b1;
        ok = (rd[1:0] === 2'b00) ? ok + 1 : 0;
        n = n + 1;
      end while (ok < 2 && n < 500);
      check("idle", n < 500, 1);
    end
  endtask
  task run(input [7:0] ctl, input [7:0] lo, input [7:0] hi, input [15:0] pd, input [4:0] n);
    begin
      apb(1'b1, `ADDR_CONTROL, {24'h0, ctl});
      apb(1'b1, `ADDR_LOW_BYTE, {24'h0, lo});
      apb(1'b1, `ADDR_HIGH_BYTE, {24'h0, hi});
      i_sync_peer_model.load(pd, n);
      apb(1'b1, `ADDR_STATUS, 32'h1);
    end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_reset;
    begin
      rdc(`ADDR_CONTROL, 32'h0, "control");
      rdc(`ADDR_STATUS, 32'h80, "status");
      rdc(`ADDR_PORT_MODE, 32'h0, "port mode");
      rdc(`ADDR_CLOCK_STOP, 32'hff, "clock stop");
      rdc(`ADDR_IRQ, 32'h0, "request");
      apb(1'b0, 12'h01c, 32'h0);
      check("unmapped", bad, 1);
    end
  endtask
  task t_xfer8;
    begin
      apb(1'b1, `ADDR_PORT_MODE, 32'h7);
      run(8'h06, 8'ha5, 8'h00, 16'h003c, 5'h08);
      apb(1'b0, `ADDR_STATUS, 32'h0);
      check("busy", rd[0], 1);
      wait_idle;
      check("done pin", done, 1);
      rdc(`ADDR_LOW_BYTE, 32'h3c, "rx low");
      check("peer rx", i_sync_peer_model.rx[15:8], 8'ha5);
      check("last bit", so_w, 1);
    end
  endtask
  task t_xfer16;
    begin
      run(8'h46, 8'h5a, 8'h81, 16'hc3e1, 5'h10);
      wait_idle;
      rdc(`ADDR_LOW_BYTE, 32'he1, "rx low");
      rdc(`ADDR_HIGH_BYTE, 32'hc3, "rx high");
      check("peer rx", i_sync_peer_model.rx, 16'h815a);
      apb(1'b1, `ADDR_IRQ, 32'h0);
      @(posedge pclk);
      check("done clear", done, 0);
    end
  endtask
  task t_ext;
    begin
      run(8'h08, 8'h0f, 8'h00, 16'h00f0, 5'h08);
      check("sck drive", sck_oe, 0);
      i_sync_peer_model.clock_out(8, 8);
      wait_idle;
      rdc(`ADDR_LOW_BYTE, 32'hf0, "ext rx");
      check("ext peer", i_sync_peer_model.rx[15:8], 8'h0f);
      i_sync_peer_model.clock_out(2, 8);
      apb(1'b0, `ADDR_STATUS, 32'h0);
      check("overrun", rd[5], 1);
      rdc(`ADDR_LOW_BYTE, 32'hf0, "no shift");
      apb(1'b1, `ADDR_STATUS, 32'h0);
      apb(1'b0, `ADDR_STATUS, 32'h0);
      check("overrun clear", rd[5], 0);
    end
  endtask
  task t_level;
    begin
      apb(1'b1, `ADDR_CONTROL, 32'h06);
      apb(1'b1, `ADDR_STATUS, 32'h0);
      repeat (2) @(posedge pclk);
      check("level low", so_w, 0);
      apb(1'b1, `ADDR_STATUS, 32'h40);
      repeat (2) @(posedge pclk);
      check("level high", so_w, 1);
      apb(1'b1, `ADDR_PORT_MODE, 32'hf);
      repeat (2) @(posedge pclk);
      check("open drain", {so_oe, so_o}, 2'b00);
      apb(1'b1, `ADDR_PORT_MODE, 32'h7);
      rdc(`ADDR_STATUS, 32'hc0, "level read");
    end
  endtask
  task t_reinit;
    begin
      run(8'h00, 8'h00, 8'h00, 16'h0000, 5'h08);
      apb(1'b1, `ADDR_CONTROL, 32'h06);
      apb(1'b0, `ADDR_STATUS, 32'h0);
      check("reinit", rd[0], 0);
    end
  endtask
  task t_tail;
    begin
      for (i = 0; i < 2; i = i + 1) begin
        tail_seen = 1'b0;
        apb(1'b1, `ADDR_IRQ, 32'h0);
        run(i ? 8'h32 : 8'h22, 8'h00, 8'h00, 16'h0000, 5'h08);
        wait_idle;
        check("tail busy", tail_seen, 1);
        check("tail end", {sck_w, so_w}, 2'b11);
        check("tail done", done, 1);
        apb(1'b1, `ADDR_IRQ, 32'h0);
      end
    end
  endtask
  task t_cont;
    begin
      apb(1'b1, `ADDR_CONTROL, 32'h86);
      edges = 0;
      last = sck_w;
      repeat (40) begin
        @(posedge pclk);
        if (sck_w !== last) edges = edges + 1;
        last = sck_w;
      end
      check("free clock", edges > 8, 1);
      apb(1'b1, `ADDR_STATUS, 32'h41);
      apb(1'b0, `ADDR_STATUS, 32'h0);
      check("start refused", rd[0], 0);
      apb(1'b1, `ADDR_CONTROL, 32'h06);
      repeat (4) @(posedge pclk);
      edges = 0;
      repeat (20) begin
        @(posedge pclk);
        if (sck_w !== 1'b1) edges = edges + 1;
      end
      check("clock still", edges, 0);
    end
  endtask
  task t_standby;
    begin
      apb(1'b1, `ADDR_LOW_BYTE, 32'h77);
      apb(1'b1, `ADDR_CLOCK_STOP, 32'h7f);
      repeat (2) @(posedge pclk);
      rdc(`ADDR_LOW_BYTE, 32'h0, "standby low");
      apb(1'b1, `ADDR_CONTROL, 32'h46);
      rdc(`ADDR_CONTROL, 32'h0, "standby ctl");
      apb(1'b1, `ADDR_CLOCK_STOP, 32'hff);
      apb(1'b1, `ADDR_CONTROL, 32'h46);
      rdc(`ADDR_CONTROL, 32'h46, "running ctl");
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (cycles == 60000) begin
      err_count = err_count + 1;
      stop_test;
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_xfer8;
    t_xfer16;
    t_ext;
    t_level;
    t_reinit;
    t_tail;
    t_cont;
    t_standby;
    stop_test;
  end
endmodule
